// ---- verilog/split_timer_pkg.sv ----
package split_timer_pkg;

  // Register addresses on the special-function-register bus
  localparam logic [7:0] ADDR_TIMER_CONTROL = 8'h91;
  localparam logic [7:0] ADDR_RELOAD_LOW_BYTE = 8'h92;
  localparam logic [7:0] ADDR_RELOAD_HIGH_BYTE = 8'h93;
  localparam logic [7:0] ADDR_COUNT_LOW_BYTE = 8'h94;
  localparam logic [7:0] ADDR_COUNT_HIGH_BYTE = 8'h95;

  // Field positions inside timer_control
  localparam int BIT_HIGH_OVERFLOW_FLAG = 7;
  localparam int BIT_LOW_OVERFLOW_FLAG = 6;
  localparam int BIT_LOW_BYTE_IRQ_ENABLE = 5;
  localparam int BIT_LFO_CAPTURE_ENABLE = 4;
  localparam int BIT_SPLIT_MODE_SELECT = 3;
  localparam int BIT_RUN_CONTROL = 2;
  localparam int BIT_UNUSED = 1;
  localparam int BIT_EXTERNAL_SOURCE_SELECT = 0;

  // Writable bits of timer_control; bit 1 is tied low
  localparam logic [7:0] CONTROL_WRITE_MASK = 8'hFD;

  // Reset values
  localparam logic [7:0] RESET_TIMER_CONTROL = 8'h00;
  localparam logic [7:0] RESET_RELOAD_LOW_BYTE = 8'h00;
  localparam logic [7:0] RESET_RELOAD_HIGH_BYTE = 8'h00;
  localparam logic [7:0] RESET_COUNT_LOW_BYTE = 8'h00;
  localparam logic [7:0] RESET_COUNT_HIGH_BYTE = 8'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // Count limits
  localparam logic [7:0] BYTE_MAX = 8'hFF;
  localparam logic [7:0] BYTE_ONE = 8'h01;

  // System clock prescaler divides by twelve
  localparam int PRESCALE_DIVIDE = 12;
  localparam logic [3:0] PRESCALE_LAST = 4'(PRESCALE_DIVIDE - 1);

  // Counting mode
  typedef enum logic {
    MODE_SIXTEEN_BIT = 1'b0,
    MODE_SPLIT = 1'b1
  } timer_mode_e;

endpackage

// ---- verilog/sync_rise_detect.sv ----
`timescale 1ns/1ps
// Two-stage synchroniser with a registered one-cycle rising-edge pulse
module sync_rise_detect
  import split_timer_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  input wire logic i_async,
  output logic o_rise
);

  typedef struct packed {
    logic meta;
    logic sync;
    logic last;
    logic rise;
  } sync_state_s;

  sync_state_s state;
  sync_state_s next_state;

  // The meta stage feeds only the sync stage
  always_comb begin
    next_state = state;
    next_state.meta = i_async;
    next_state.sync = state.meta;
    next_state.last = state.sync;
    next_state.rise = state.sync & ~state.last;
  end

  // Frozen while the clock enable is low
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state <= '0;
    end else if (i_ce) begin
      state <= next_state;
    end
  end

  assign o_rise = state.rise;

endmodule

// ---- verilog/prescale_div12.sv ----
`timescale 1ns/1ps
// Free-running prescaler giving one tick every twelve system clocks
module prescale_div12
  import split_timer_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  output logic o_tick
);

  typedef struct packed {
    logic [3:0] phase;
    logic tick;
  } prescale_state_s;

  prescale_state_s state;
  prescale_state_s next_state;

  // Wrap the phase and flag the last one
  always_comb begin
    next_state = state;
    next_state.tick = (state.phase == PRESCALE_LAST);
    if (state.phase == PRESCALE_LAST) begin
      next_state.phase = '0;
    end else begin
      next_state.phase = state.phase + 4'h1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state <= '0;
    end else if (i_ce) begin
      state <= next_state;
    end
  end

  assign o_tick = state.tick;

endmodule

// ---- verilog/split_autoreload_timer.sv ----
`timescale 1ns/1ps
module split_autoreload_timer
  import split_timer_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic i_sfr_rd,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic i_high_byte_clock_select,
  input wire logic i_low_byte_clock_select,
  input wire logic i_timer_irq_enable,
  input wire logic i_ext_clk_div8,
  input wire logic i_lfo_out,
  output logic [7:0] o_sfr_rdata,
  output logic o_irq_request,
  output logic o_high_overflow_flag,
  output logic o_low_overflow_flag
);

  // Every register of the timer in one word, so reset and freeze act together
  typedef struct packed {
    logic [7:0] timer_control;
    logic [7:0] reload_low_byte;
    logic [7:0] reload_high_byte;
    logic [7:0] count_low_byte;
    logic [7:0] count_high_byte;
    logic [7:0] rdata;
    logic irq;
  } timer_state_s;

  // The register itself, and its value for the coming edge
  timer_state_s state;
  timer_state_s next_state;

  // One-cycle enables from the prescaler and the two synchronisers
  logic div12_tick;
  logic ext_tick;
  logic lfo_rise;

  // Cycle enables for the two bytes
  // Nothing here is a clock; every byte runs on i_clk alone
  logic low_tick;
  logic high_tick;
  logic low_advance;
  logic high_advance;

  // Overflow and capture events of this cycle
  // These strobes last one cycle and are never stored as such
  logic low_wrap;
  logic high_wrap;
  logic full_wrap;
  logic capture_event;
  logic low_irq_event;
  logic high_irq_event;

  // Decoded control fields
  // Flags are not decoded here; they feed only the outputs and reads
  timer_mode_e mode;
  logic run;
  logic ext_select;
  logic low_irq_en;
  logic capture_en;

  // Register write strobes
  // Unmapped addresses raise no strobe, so such writes are ignored
  logic wr_control;
  logic wr_reload_low;
  logic wr_reload_high;
  logic wr_count_low;
  logic wr_count_high;

  // Next count values before software writes are applied
  // Kept apart so a same-cycle software write can override them
  logic [7:0] count_low_next;
  logic [7:0] count_high_next;
  logic [7:0] read_value;

  // System clock divided by twelve
  // Shared by both bytes, so split timers on the same source tick together
  // Its phase ignores writes, so the first tick after a start may come early
  prescale_div12 u_prescale (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_ce(i_ce),
    .o_tick(div12_tick)
  );

  // external clock synchroniser
  // Input may be asynchronous; a pulse shorter than a cycle can be missed
  sync_rise_detect u_ext_sync (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_ce(i_ce),
    .i_async(i_ext_clk_div8),
    .o_rise(ext_tick)
  );

  // Low-frequency oscillator edges for capture
  // Same latency as the external path, so a capture sees a settled count
  sync_rise_detect u_lfo_sync (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_ce(i_ce),
    .i_async(i_lfo_out),
    .o_rise(lfo_rise)
  );

  // Control field decode
  // Taken from stored bits, so a control write acts from the next cycle
  always_comb begin
    mode = timer_mode_e'(state.timer_control[BIT_SPLIT_MODE_SELECT]);
    run = state.timer_control[BIT_RUN_CONTROL];
    ext_select = state.timer_control[BIT_EXTERNAL_SOURCE_SELECT];
    low_irq_en = state.timer_control[BIT_LOW_BYTE_IRQ_ENABLE];
    capture_en = state.timer_control[BIT_LFO_CAPTURE_ENABLE];
  end

  // Address decode of bus writes
  // A strobe held high repeats the write in every cycle
  always_comb begin
    wr_control = i_sfr_wr & (i_sfr_addr == ADDR_TIMER_CONTROL);
    wr_reload_low = i_sfr_wr & (i_sfr_addr == ADDR_RELOAD_LOW_BYTE);
    wr_reload_high = i_sfr_wr & (i_sfr_addr == ADDR_RELOAD_HIGH_BYTE);
    wr_count_low = i_sfr_wr & (i_sfr_addr == ADDR_COUNT_LOW_BYTE);
    wr_count_high = i_sfr_wr & (i_sfr_addr == ADDR_COUNT_HIGH_BYTE);
  end

  // per-byte clock selection as cycle enables
  // A select of one counts every system clock whatever the source bit says
  // No divided clock is made, which keeps the block in one clock domain
  always_comb begin
    if (i_high_byte_clock_select) begin
      high_tick = 1'b1;
    end else if (ext_select) begin
      high_tick = ext_tick;
    end else begin
      high_tick = div12_tick;
    end
    if (i_low_byte_clock_select) begin
      low_tick = 1'b1;
    end else if (ext_select) begin
      low_tick = ext_tick;
    end else begin
      low_tick = div12_tick;
    end
  end

  // Which bytes advance this cycle
  // Default arm is unreachable with a two-valued mode and simply holds
  always_comb begin
    case (mode)
      // run bit gates the whole 16-bit timer
      MODE_SIXTEEN_BIT: begin
        low_advance = run & low_tick;
        high_advance = 1'b0;
      end
      // low byte free-running, high byte gated
      MODE_SPLIT: begin
        low_advance = low_tick;
        high_advance = run & high_tick;
      end
      default: begin
        low_advance = 1'b0;
        high_advance = 1'b0;
      end
    endcase
  end

  // Wrap detection from the current count
  // Judged on the value before the edge, so a reload, its flag and the
  // interrupt pulse all land on the same edge
  always_comb begin
    low_wrap = low_advance & (state.count_low_byte == BYTE_MAX);
    full_wrap = (mode == MODE_SIXTEEN_BIT) & low_wrap & (state.count_high_byte == BYTE_MAX);
    high_wrap = full_wrap | (high_advance & (state.count_high_byte == BYTE_MAX));
    capture_event = capture_en & lfo_rise;
  end

  // Count arithmetic for both modes
  // In 16-bit mode the high byte moves only on a carry out of the low byte
  always_comb begin
    count_low_next = state.count_low_byte;
    count_high_next = state.count_high_byte;
    case (mode)
      MODE_SIXTEEN_BIT: begin
        if (full_wrap) begin
          // reload the full 16-bit pair on overflow
          count_low_next = state.reload_low_byte;
          count_high_next = state.reload_high_byte;
        end else if (low_wrap) begin
          // Carry from the low byte into the high byte
          // The low byte wraps to zero here; the reload applies only on full wrap
          count_low_next = 8'h00;
          count_high_next = state.count_high_byte + BYTE_ONE;
        end else if (low_advance) begin
          count_low_next = state.count_low_byte + BYTE_ONE;
        end
      end
      MODE_SPLIT: begin
        // independent 8-bit reloads
        // Each byte wraps and reloads on its own tick, never carrying
        if (low_wrap) begin
          count_low_next = state.reload_low_byte;
        end else if (low_advance) begin
          count_low_next = state.count_low_byte + BYTE_ONE;
        end
        if (high_advance && (state.count_high_byte == BYTE_MAX)) begin
          count_high_next = state.reload_high_byte;
        end else if (high_advance) begin
          count_high_next = state.count_high_byte + BYTE_ONE;
        end
      end
      default: begin
        count_low_next = state.count_low_byte;
        count_high_next = state.count_high_byte;
      end
    endcase
  end

  // Interrupt request events
  // Coinciding events give one pulse; software tells them apart by the
  // two overflow flags
  always_comb begin
    // every high-byte overflow requests an interrupt while i_timer_irq_enable is high
    high_irq_event = i_timer_irq_enable & high_wrap;
    // low-byte wraps request only with the low enable
    low_irq_event = i_timer_irq_enable & low_irq_en & low_wrap;
  end

  // Read multiplexer; reads have no side effects
  // Decoded from the address alone; the read strobe only loads the data register
  always_comb begin
    case (i_sfr_addr)
      // bit 1 is held at zero in storage
      ADDR_TIMER_CONTROL: read_value = state.timer_control;
      ADDR_RELOAD_LOW_BYTE: read_value = state.reload_low_byte;
      ADDR_RELOAD_HIGH_BYTE: read_value = state.reload_high_byte;
      ADDR_COUNT_LOW_BYTE: read_value = state.count_low_byte;
      ADDR_COUNT_HIGH_BYTE: read_value = state.count_high_byte;
      default: read_value = READ_UNMAPPED;
    endcase
  end

  // Next-state assembly
  always_comb begin
    next_state = state;

    // Later assignments in this block win, so the order below is the priority
    // Control register: software value, then hardware flag sets on top
    if (wr_control) begin
      // written value to bit 1 is dropped
      next_state.timer_control = i_sfr_wdata & CONTROL_WRITE_MASK;
    end
    // flags set by hardware or by a software write of one; a hardware set wins over a clear
    // Software may still write a flag to one, which sets it
    if (high_wrap) begin
      next_state.timer_control[BIT_HIGH_OVERFLOW_FLAG] = 1'b1;
    end
    if (low_wrap) begin
      next_state.timer_control[BIT_LOW_OVERFLOW_FLAG] = 1'b1;
    end

    // Reload registers; a capture beats a same-cycle software write
    // The capture is the newer information, so the software byte is lost
    if (wr_reload_low) begin
      next_state.reload_low_byte = i_sfr_wdata;
    end
    if (wr_reload_high) begin
      next_state.reload_high_byte = i_sfr_wdata;
    end
    if (capture_event) begin
      // snapshot the current count into the reload pair
      next_state.reload_low_byte = state.count_low_byte;
      next_state.reload_high_byte = state.count_high_byte;
    end

    // Counts; a software write overrides the advance of that byte
    // A write in a wrap cycle keeps the written value, but the flag still sets
    next_state.count_low_byte = count_low_next;
    next_state.count_high_byte = count_high_next;
    if (wr_count_low) begin
      next_state.count_low_byte = i_sfr_wdata;
    end
    if (wr_count_high) begin
      next_state.count_high_byte = i_sfr_wdata;
    end

    // Read data is registered and holds between reads
    // A slow master may therefore sample it several cycles late
    if (i_sfr_rd) begin
      next_state.rdata = read_value;
    end

    // capture also requests an interrupt
    // Capture sets no flag, so software sees it only as this pulse
    next_state.irq = high_irq_event | low_irq_event | (i_timer_irq_enable & capture_event);
  end

  // State register, frozen while the clock enable is low
  // Reset acts even while the clock enable is low
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state.timer_control <= RESET_TIMER_CONTROL;
      state.reload_low_byte <= RESET_RELOAD_LOW_BYTE;
      state.reload_high_byte <= RESET_RELOAD_HIGH_BYTE;
      state.count_low_byte <= RESET_COUNT_LOW_BYTE;
      state.count_high_byte <= RESET_COUNT_HIGH_BYTE;
      state.rdata <= READ_UNMAPPED;
      state.irq <= 1'b0;
    end else if (i_ce) begin
      state <= next_state;
    end
  end

  // Outputs straight from the state register
  // The flags are the control bits themselves, with no extra stage
  assign o_sfr_rdata = state.rdata;
  assign o_irq_request = state.irq;
  assign o_high_overflow_flag = state.timer_control[BIT_HIGH_OVERFLOW_FLAG];
  assign o_low_overflow_flag = state.timer_control[BIT_LOW_OVERFLOW_FLAG];

endmodule

// ---- verification/split_autoreload_timer_checker.sv ----
`timescale 1ns/1ps
module split_autoreload_timer_checker
  import split_timer_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic i_sfr_rd,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic i_high_byte_clock_select,
  input wire logic i_low_byte_clock_select,
  input wire logic i_timer_irq_enable,
  input wire logic i_ext_clk_div8,
  input wire logic i_lfo_out,
  input wire logic [7:0] o_sfr_rdata,
  input wire logic o_irq_request,
  input wire logic o_high_overflow_flag,
  input wire logic o_low_overflow_flag
);
  logic [7:0] ctrl;
  logic ctrl_wr;
  logic rd_take;
  // Decoded bus strobes
  assign ctrl_wr = i_ce && i_sfr_wr && (i_sfr_addr == ADDR_TIMER_CONTROL);
  assign rd_take = i_ce && i_sfr_rd;
  // Mirror of control writes; the flags are not mirrored, only mode and enables matter
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      ctrl <= 8'h00;
    end else if (ctrl_wr) begin
      ctrl <= i_sfr_wdata;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);
  bit_one_zero_a: assert property (
    rd_take && i_sfr_addr == ADDR_TIMER_CONTROL |=> !o_sfr_rdata[BIT_UNUSED])
    else $error("control bit 1 read back as one");
  unmapped_read_a: assert property (
    rd_take && (i_sfr_addr < ADDR_TIMER_CONTROL || i_sfr_addr > ADDR_COUNT_HIGH_BYTE)
    |=> o_sfr_rdata == READ_UNMAPPED) else $error("unmapped read not zero");
  high_flag_kept_a: assert property (
    $fell(o_high_overflow_flag) && !$past(i_srst) |-> $past(ctrl_wr && !i_sfr_wdata[7]))
    else $error("high flag cleared without a write");
  low_flag_kept_a: assert property (
    $fell(o_low_overflow_flag) && !$past(i_srst) |-> $past(ctrl_wr && !i_sfr_wdata[6]))
    else $error("low flag cleared without a write");
  irq_gated_a: assert property (
    o_irq_request |-> $past(i_timer_irq_enable)) else $error("interrupt while disabled");
  full_wrap_a: assert property (
    $rose(o_high_overflow_flag) && !$past(ctrl_wr) && !$past(ctrl[3]) |-> o_low_overflow_flag)
    else $error("full wrap left low flag clear");
  high_irq_a: assert property (
    $rose(o_high_overflow_flag) && !$past(ctrl_wr) && $past(i_timer_irq_enable)
    |-> o_irq_request) else $error("high overflow without interrupt");
  low_irq_a: assert property (
    $rose(o_low_overflow_flag) && !$past(ctrl_wr) && $past(i_timer_irq_enable && ctrl[5])
    |-> o_irq_request) else $error("low overflow without interrupt");
  irq_cause_a: assert property (
    o_irq_request && !$past(ctrl[5]) && !$past(ctrl[4]) |-> o_high_overflow_flag)
    else $error("interrupt without a cause");
  // Main scenarios reached
  cover property ($rose(o_high_overflow_flag) && ctrl[3]);
  cover property ($rose(o_low_overflow_flag) && !o_high_overflow_flag);
  cover property (o_irq_request && ctrl[4]);
endmodule

bind split_autoreload_timer split_autoreload_timer_checker split_autoreload_timer_checker_i (
  .i_clk(i_clk), .i_srst(i_srst), .i_ce(i_ce), .i_sfr_addr(i_sfr_addr),
  .i_sfr_wr(i_sfr_wr), .i_sfr_rd(i_sfr_rd), .i_sfr_wdata(i_sfr_wdata),
  .i_high_byte_clock_select(i_high_byte_clock_select),
  .i_low_byte_clock_select(i_low_byte_clock_select),
  .i_timer_irq_enable(i_timer_irq_enable), .i_ext_clk_div8(i_ext_clk_div8),
  .i_lfo_out(i_lfo_out), .o_sfr_rdata(o_sfr_rdata), .o_irq_request(o_irq_request),
  .o_high_overflow_flag(o_high_overflow_flag), .o_low_overflow_flag(o_low_overflow_flag)
);

// ---- verification/split_autoreload_timer_bench.sv ----
`timescale 1ns/1ps
module split_autoreload_timer_bench
  import split_timer_pkg::*;
;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic hsel = 1'b1;
  logic lsel = 1'b1;
  logic irq_en = 1'b1;
  logic ext = 1'b0;
  logic lfo = 1'b0;
  logic [7:0] rdata;
  logic irq;
  logic hflag;
  logic lflag;
  int n_mismatch = 0;
  int checked = 0;
  // 125 MHz system clock
  always #4 clk = ~clk;
  split_autoreload_timer split_autoreload_timer_i (
    .i_clk(clk), .i_srst(srst), .i_ce(ce), .i_sfr_addr(addr), .i_sfr_wr(wr_s),
    .i_sfr_rd(rd_s), .i_sfr_wdata(wdata), .i_high_byte_clock_select(hsel),
    .i_low_byte_clock_select(lsel), .i_timer_irq_enable(irq_en), .i_ext_clk_div8(ext),
    .i_lfo_out(lfo), .o_sfr_rdata(rdata), .o_irq_request(irq),
    .o_high_overflow_flag(hflag), .o_low_overflow_flag(lflag)
  );
  function automatic logic [7:0] flg();
    return {6'h00, hflag, lflag};
  endfunction
  task end_of_test;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Bus cycles start on a falling edge, so an idle cycle always separates strobes
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr_s = 1'b1;
    @(negedge clk);
    wr_s = 1'b0;
  endtask
  task rdv(input logic [7:0] a, output logic [7:0] v);
    @(negedge clk);
    addr = a;
    rd_s = 1'b1;
    @(negedge clk);
    rd_s = 1'b0;
    v = rdata;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rdv(a, v);
    chk(v, exp);
  endtask
  // Bounded wait; a missing pulse counts as a mismatch
  task wait_irq;
    int k;
    k = 0;
    while (irq !== 1'b1 && k < 2000) begin
      @(negedge clk);
      k++;
    end
    chk({7'h00, irq}, 8'h01);
  endtask
  task t_regs;
    for (int a = 8'h90; a <= 8'h96; a++) rd(8'(a), 8'h00);
    wr(ADDR_TIMER_CONTROL, 8'hFF);
    rd(ADDR_TIMER_CONTROL, 8'hFD);
    wr(ADDR_TIMER_CONTROL, 8'h00);
    wr(ADDR_COUNT_LOW_BYTE, 8'hA5);
    wr(ADDR_COUNT_HIGH_BYTE, 8'h5A);
    // A start written while the clock enable is low must be lost
    ce = 1'b0;
    wr(ADDR_TIMER_CONTROL, 8'h04);
    ce = 1'b1;
    repeat (20) @(negedge clk);
    rd(ADDR_TIMER_CONTROL, 8'h00);
    rd(ADDR_COUNT_LOW_BYTE, 8'hA5);
    rd(ADDR_COUNT_HIGH_BYTE, 8'h5A);
    $display("test regs done");
  endtask
  task t_wrap16;
    wr(ADDR_RELOAD_LOW_BYTE, 8'h34);
    wr(ADDR_RELOAD_HIGH_BYTE, 8'h12);
    wr(ADDR_COUNT_LOW_BYTE, 8'hF0);
    wr(ADDR_COUNT_HIGH_BYTE, 8'hFF);
    wr(ADDR_TIMER_CONTROL, 8'h04);
    wait_irq;
    chk(flg(), 8'h03);
    rd(ADDR_COUNT_LOW_BYTE, 8'h35);
    rd(ADDR_COUNT_HIGH_BYTE, 8'h12);
    repeat (300) @(negedge clk);
    chk(flg(), 8'h03);
    wr(ADDR_TIMER_CONTROL, 8'h24);
    wait_irq;
    chk(flg(), 8'h01);
    $display("test wrap16 done");
  endtask
  // Reads land two cycles after the wrap edge, one tick past the reload value
  task t_split;
    wr(ADDR_TIMER_CONTROL, 8'h00);
    wr(ADDR_RELOAD_LOW_BYTE, 8'h80);
    wr(ADDR_RELOAD_HIGH_BYTE, 8'h40);
    wr(ADDR_COUNT_LOW_BYTE, 8'hFE);
    wr(ADDR_COUNT_HIGH_BYTE, 8'h50);
    wr(ADDR_TIMER_CONTROL, 8'h28);
    wait_irq;
    chk(flg(), 8'h01);
    rd(ADDR_COUNT_LOW_BYTE, 8'h81);
    rd(ADDR_COUNT_HIGH_BYTE, 8'h50);
    wr(ADDR_COUNT_HIGH_BYTE, 8'hFF);
    wr(ADDR_TIMER_CONTROL, 8'h0C);
    wait_irq;
    chk({7'h00, hflag}, 8'h01);
    rd(ADDR_COUNT_HIGH_BYTE, 8'h41);
    $display("test split done");
  endtask
  // Count both bytes over a fixed span and compare the advance
  task span(input logic [7:0] exp_adv, input logic use_ext);
    logic [7:0] l0, h0, l1, h1;
    wr(ADDR_COUNT_LOW_BYTE, 8'h00);
    wr(ADDR_COUNT_HIGH_BYTE, 8'h00);
    rdv(ADDR_COUNT_LOW_BYTE, l0);
    rdv(ADDR_COUNT_HIGH_BYTE, h0);
    if (use_ext) begin
      repeat (5) begin
        ext = 1'b1;
        repeat (3) @(negedge clk);
        ext = 1'b0;
        repeat (3) @(negedge clk);
      end
      repeat (4) @(negedge clk);
    end else begin
      repeat (116) @(negedge clk);
    end
    rdv(ADDR_COUNT_LOW_BYTE, l1);
    rdv(ADDR_COUNT_HIGH_BYTE, h1);
    chk(l1 - l0, exp_adv);
    chk(h1 - h0, exp_adv);
  endtask
  task t_clocks;
    hsel = 1'b0;
    lsel = 1'b0;
    wr(ADDR_TIMER_CONTROL, 8'h0C);
    span(8'h0A, 1'b0);
    wr(ADDR_TIMER_CONTROL, 8'h0D);
    span(8'h05, 1'b1);
    hsel = 1'b1;
    lsel = 1'b1;
    $display("test clocks done");
  endtask
  task t_capture;
    logic seen;
    wr(ADDR_TIMER_CONTROL, 8'h00);
    wr(ADDR_COUNT_LOW_BYTE, 8'h77);
    wr(ADDR_COUNT_HIGH_BYTE, 8'h66);
    wr(ADDR_TIMER_CONTROL, 8'h10);
    @(negedge clk);
    lfo = 1'b1;
    wait_irq;
    rd(ADDR_RELOAD_LOW_BYTE, 8'h77);
    rd(ADDR_RELOAD_HIGH_BYTE, 8'h66);
    // Second capture with timer interrupts off: the copy happens, no pulse
    lfo = 1'b0;
    irq_en = 1'b0;
    wr(ADDR_COUNT_LOW_BYTE, 8'h11);
    wr(ADDR_COUNT_HIGH_BYTE, 8'h22);
    lfo = 1'b1;
    seen = 1'b0;
    repeat (8) begin
      @(negedge clk);
      if (irq !== 1'b0) seen = 1'b1;
    end
    chk({7'h00, seen}, 8'h00);
    rd(ADDR_RELOAD_LOW_BYTE, 8'h11);
    rd(ADDR_RELOAD_HIGH_BYTE, 8'h22);
    lfo = 1'b0;
    irq_en = 1'b1;
    $display("test capture done");
  endtask
  // Main sequence
  initial begin
    repeat (5) @(negedge clk);
    srst = 1'b0;
    t_regs;
    t_wrap16;
    t_split;
    t_clocks;
    t_capture;
    end_of_test;
  end
  // Watchdog well beyond the several hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    end_of_test;
  end
endmodule
